// *** gpeu_top.sv ***
// General-purpose event and I/O unit: sticky event flags, enables, pin levels
`timescale 1ns/1ps
// Notes on behaviour
// - Software change of socket supply or programming power sets status bit 7.
// - Requested programming voltage moving to or from 12 V sets status bit 6.
// - Bit 5 of status and enable always reads zero; writes ignored.
// - Input flags 4..0 set on level change, only while terminal is an input.
// - Inputs 4,3,2,1,0 map to terminals 5,4,2,1,0.
// - Status flags set by hardware, cleared by software, reset to zero.
// - Enable bits 7,6,4..0 read/write; set bit lets its flag drive event.
// - Status events can be programmed to signal on the event output.
// - The global reset is the only reset of flags, enables and outputs.
// - Input register bits 4..0 show current input levels.
// - Output register bits 4..0 read/write, reset zero, drive output levels.
// - Bits 7..5 of input and output registers read zero; writes ignored.
// - Terminal 5 is input 4 for code 0000, output 4 for 0001.
// - Code 1110 puts the low-active event output on terminals 5, 4, 2.
module gpeu_top
    import gpeu_pkg::*;
#(
    parameter int NUM_GPI = GPEU_NUM_GPI
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire gpeu_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic power_change_i,
    input wire logic prog_voltage_12v_i,
    input wire gpeu_term_sel_t term_sel_i,
    input wire logic [4:0] term_in_i,
    output logic [4:0] term_out_o,
    output logic [4:0] term_oe_n_o,
    output logic system_event_out_n_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NUM_GPI != GPEU_NUM_GPI) begin : g_bad_gpi
        $error("gpeu_top: NUM_GPI must match the five shared terminals");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic sel_is(input logic [3:0] sel, input logic [3:0] code);
        sel_is = (sel == code);
    endfunction : sel_is

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
        addr_hit = (addr == ofs);
    endfunction : addr_hit

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [3:0] sel_arr [NUM_GPI];
    logic [NUM_GPI-1:0] is_gpi;
    logic [NUM_GPI-1:0] is_gpo;
    logic [NUM_GPI-1:0] is_evt;
    logic [NUM_GPI-1:0] pin_level;
    logic [NUM_GPI-1:0] prev_level;
    logic [NUM_GPI-1:0] gpi_change;
    logic [GPEU_SETTLE_CYCLES-1:0] settle;
    logic settled;
    logic vpp_prev;
    logic vpp_change;
    logic [7:0] flags;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [7:0] enable;
    logic [7:0] output_levels;
    logic [7:0] input_levels;
    logic wr_status;
    logic wr_enable;
    logic wr_output;
    logic next_event_n;
    logic [4:0] next_term_out;
    logic [4:0] next_term_oe_n;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // Terminal selection decode
    // ------------------------------------------------------------
    assign sel_arr[4] = term_sel_i.term5;
    assign sel_arr[3] = term_sel_i.term4;
    assign sel_arr[2] = term_sel_i.term2;
    assign sel_arr[1] = term_sel_i.term1;
    assign sel_arr[0] = term_sel_i.term0;

    for (genvar i = 0; i < NUM_GPI; i++) begin : g_decode
        assign is_gpi[i] = sel_is(sel_arr[i], GPEU_SEL_GPI);
        assign is_gpo[i] = sel_is(sel_arr[i], GPEU_SEL_GPO);
        assign is_evt[i] = sel_is(sel_arr[i], GPEU_SEL_EVT) & GPEU_EVT_CAPABLE[i];
    end

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    assign wr_status = reg_req_i.wr & addr_hit(reg_req_i.addr, GPEU_OFS_STATUS);
    assign wr_enable = reg_req_i.wr & addr_hit(reg_req_i.addr, GPEU_OFS_ENABLE);
    assign wr_output = reg_req_i.wr & addr_hit(reg_req_i.addr, GPEU_OFS_OUTPUT);

    // ------------------------------------------------------------
    // Input pins and change detection
    // ------------------------------------------------------------
    gpeu_sync #(
        .WIDTH(NUM_GPI)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .async_i(term_in_i),
        .sync_o(pin_level)
    );

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            settle <= '0;
            prev_level <= '0;
            vpp_prev <= 1'b0;
        end else begin
            settle <= {settle[GPEU_SETTLE_CYCLES-2:0], 1'b1};
            prev_level <= pin_level;
            vpp_prev <= prog_voltage_12v_i;
        end
    end

    // No change is reported until the history flops hold real samples
    assign settled = settle[GPEU_SETTLE_CYCLES-1];
    assign gpi_change = is_gpi & (pin_level ^ prev_level) & {NUM_GPI{settled}};
    assign vpp_change = settled & (prog_voltage_12v_i ^ vpp_prev);
    assign input_levels = {3'b000, pin_level};

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    assign flag_set = {power_change_i, vpp_change, 1'b0, gpi_change};
    assign flag_clr = wr_status ? (reg_req_i.wdata & GPEU_EVENT_MASK) : '0;

    gpeu_flag_bank #(
        .WIDTH(GPEU_REG_W),
        .RESET_VAL(GPEU_STATUS_RESET)
    ) u_flags (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .set_i(flag_set),
        .clr_i(flag_clr),
        .flags_o(flags)
    );

    // ------------------------------------------------------------
    // Enable and output registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enable <= GPEU_ENABLE_RESET;
            output_levels <= GPEU_OUTPUT_RESET;
        end else begin
            if (wr_enable) begin
                enable <= reg_req_i.wdata & GPEU_EVENT_MASK;
            end
            if (wr_output) begin
                output_levels <= reg_req_i.wdata & GPEU_LEVEL_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Event output and terminal drive
    // ------------------------------------------------------------
    assign next_event_n = ~|(flags & enable);

    for (genvar i = 0; i < NUM_GPI; i++) begin : g_drive
        assign next_term_oe_n[i] = ~(is_gpo[i] | is_evt[i]);
        assign next_term_out[i] = is_gpo[i] ? output_levels[i] : (is_evt[i] & next_event_n);
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    assign next_rdata = addr_hit(reg_req_i.addr, GPEU_OFS_STATUS) ? flags :
                        addr_hit(reg_req_i.addr, GPEU_OFS_ENABLE) ? enable :
                        addr_hit(reg_req_i.addr, GPEU_OFS_INPUT) ? input_levels :
                        addr_hit(reg_req_i.addr, GPEU_OFS_OUTPUT) ? output_levels : GPEU_RDATA_RESET;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            system_event_out_n_o <= 1'b1;
            term_out_o <= '0;
            term_oe_n_o <= '1;
            reg_rdata_o <= GPEU_RDATA_RESET;
        end else begin
            system_event_out_n_o <= next_event_n;
            term_out_o <= next_term_out;
            term_oe_n_o <= next_term_oe_n;
            if (reg_req_i.rd) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    a_power_flag_set: assert property (
        power_change_i |=> flags[GPEU_BIT_POWER] ##1 (flags[GPEU_BIT_POWER] || $past(wr_status)))
        else $error("power change did not set its flag");

    a_progv_flag_set: assert property (
        (settled && (prog_voltage_12v_i != vpp_prev)) |=> flags[GPEU_BIT_PROGV])
        else $error("programming voltage change did not set its flag");

    a_rsvd_bit_zero: assert property (
        !flags[GPEU_BIT_RSVD] && !enable[GPEU_BIT_RSVD])
        else $error("reserved status or enable bit became one");

    a_gpi_flag_set: assert property (
        (settled && is_gpi[0] && (pin_level[0] != prev_level[0])) |=> flags[0])
        else $error("input level change did not set its flag");

    a_flag_needs_gpi: assert property (
        $rose(flags[3]) |-> $past(is_gpi[3]))
        else $error("input flag set while terminal not an input");

    a_flag_clear_write: assert property (
        $fell(flags[0]) |-> ($past(wr_status) && $past(reg_req_i.wdata[0])))
        else $error("input flag cleared without a write of one");

    a_event_out_low: assert property (
        (|(flags & enable)) |=> !system_event_out_n_o)
        else $error("event output not asserted for enabled flag");

    a_event_out_high: assert property (
        (~|(flags & enable)) [*2] |=> system_event_out_n_o)
        else $error("event output asserted with no enabled flag");

    a_gpo_drive_pin: assert property (
        is_gpo[4] |=> (!term_oe_n_o[4] && (term_out_o[4] == $past(output_levels[4]))))
        else $error("output level not driven on selected terminal");

    a_evt_on_pin: assert property (
        is_evt[3] |=> (!term_oe_n_o[3] && (term_out_o[3] == system_event_out_n_o)))
        else $error("event output not carried on selected terminal");

    a_input_reg_tracks: assert property (
        term_in_i[2] [*3] |-> input_levels[2])
        else $error("input register does not follow pin level");

    a_level_rsvd_zero: assert property (
        (output_levels[7:5] == 3'b000) && (input_levels[7:5] == 3'b000))
        else $error("reserved level bits not zero");

    a_read_status: assert property (
        (reg_req_i.rd && addr_hit(reg_req_i.addr, GPEU_OFS_STATUS)) |=> (reg_rdata_o == $past(flags)))
        else $error("status read returned wrong value");

    a_read_enable: assert property (
        (reg_req_i.rd && addr_hit(reg_req_i.addr, GPEU_OFS_ENABLE)) |=> (reg_rdata_o == $past(enable)))
        else $error("enable read returned wrong value");

    a_read_input: assert property (
        (reg_req_i.rd && addr_hit(reg_req_i.addr, GPEU_OFS_INPUT)) |=> (reg_rdata_o == $past(input_levels)))
        else $error("input read returned wrong value");

    a_read_output: assert property (
        (reg_req_i.rd && addr_hit(reg_req_i.addr, GPEU_OFS_OUTPUT)) |=> (reg_rdata_o == $past(output_levels)))
        else $error("output read returned wrong value");

    a_enable_write: assert property (
        wr_enable |=> (enable == ($past(reg_req_i.wdata) & GPEU_EVENT_MASK)))
        else $error("enable register did not take written value");

    a_enable_hold: assert property (
        !wr_enable |=> $stable(enable))
        else $error("enable register changed without a write");

    a_output_write: assert property (
        wr_output |=> (output_levels == ($past(reg_req_i.wdata) & GPEU_LEVEL_MASK)))
        else $error("output register did not take written value");

    a_power_flag_sticky: assert property (
        (flags[GPEU_BIT_POWER] && !wr_status) |=> flags[GPEU_BIT_POWER])
        else $error("power flag cleared without a status write");

    a_progv_no_change: assert property (
        (!flags[GPEU_BIT_PROGV] && (prog_voltage_12v_i == vpp_prev)) |=> !flags[GPEU_BIT_PROGV])
        else $error("programming voltage flag set without a change");

    a_flag_blocked: assert property (
        (!is_gpi[4] && !flags[4]) |=> !flags[4])
        else $error("input 4 flag set while terminal not an input");

    a_gpo_pin_zero: assert property (
        is_gpo[0] |=> (!term_oe_n_o[0] && (term_out_o[0] == $past(output_levels[0]))))
        else $error("output level 0 not driven on selected terminal");

    a_evt_pin_blocked: assert property (
        (term_sel_i.term1 == GPEU_SEL_EVT) |=> term_oe_n_o[1])
        else $error("event code drove a terminal that cannot carry it");

endmodule : gpeu_top

// *** gpeu_pkg.sv ***
// Constants and carrier types for the general-purpose event and I/O unit
package gpeu_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] GPEU_OFS_STATUS = 8'h88;
    localparam logic [7:0] GPEU_OFS_ENABLE = 8'h89;
    localparam logic [7:0] GPEU_OFS_INPUT = 8'h8A;
    localparam logic [7:0] GPEU_OFS_OUTPUT = 8'h8B;

    // ------------------------------------------------------------
    // Field positions, masks and reset values
    // ------------------------------------------------------------
    localparam int GPEU_REG_W = 8;
    localparam int GPEU_NUM_GPI = 5;
    localparam int GPEU_BIT_POWER = 7;
    localparam int GPEU_BIT_PROGV = 6;
    localparam int GPEU_BIT_RSVD = 5;
    localparam logic [7:0] GPEU_EVENT_MASK = 8'hDF;
    localparam logic [7:0] GPEU_LEVEL_MASK = 8'h1F;
    localparam logic [7:0] GPEU_STATUS_RESET = 8'h00;
    localparam logic [7:0] GPEU_ENABLE_RESET = 8'h00;
    localparam logic [7:0] GPEU_OUTPUT_RESET = 8'h00;
    localparam logic [7:0] GPEU_RDATA_RESET = 8'h00;

    // ------------------------------------------------------------
    // Terminal selection codes
    // ------------------------------------------------------------
    localparam logic [3:0] GPEU_SEL_GPI = 4'h0;
    localparam logic [3:0] GPEU_SEL_GPO = 4'h1;
    localparam logic [3:0] GPEU_SEL_EVT = 4'hE;
    // Inputs 4, 3, 2 sit on terminals that can carry the event output
    localparam logic [4:0] GPEU_EVT_CAPABLE = 5'h1C;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int GPEU_SETTLE_CYCLES = 3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpeu_reg_req_t;

    typedef struct packed {
        logic [3:0] term5;
        logic [3:0] term4;
        logic [3:0] term2;
        logic [3:0] term1;
        logic [3:0] term0;
    } gpeu_term_sel_t;

endpackage : gpeu_pkg

// *** gpeu_sync.sv ***
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module gpeu_sync #(
    parameter int WIDTH = 5
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    if (WIDTH < 1) begin : g_bad_width
        $error("gpeu_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule : gpeu_sync

// *** gpeu_flag_bank.sv ***
// Sticky flag bank, set by hardware and cleared by writing ones
`timescale 1ns/1ps
module gpeu_flag_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] flags_o
);

    logic [WIDTH-1:0] next_flags;

    if (WIDTH < 1) begin : g_bad_width
        $error("gpeu_flag_bank: WIDTH must be at least 1");
    end

    // Set wins over a clear in the same cycle
    assign next_flags = (flags_o & ~clr_i) | set_i;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_o <= RESET_VAL;
        end else begin
            flags_o <= next_flags;
        end
    end

endmodule : gpeu_flag_bank

// *** gpeu_board.sv ***
// Board-side model of the five shared terminals
`timescale 1ns/1ps
module gpeu_board (
    input wire logic [4:0] ext_level_i,
    input wire logic [4:0] dev_out_i,
    input wire logic [4:0] dev_oe_n_i,
    output logic [4:0] pin_level_o
);
    // Driven terminals follow the device, released ones the board source
    assign pin_level_o = (dev_oe_n_i & ext_level_i) | (~dev_oe_n_i & dev_out_i);
endmodule : gpeu_board

// *** tb.sv ***
// Self-checking testbench for the event and I/O unit
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb
    import gpeu_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    gpeu_reg_req_t req = '0;
    logic pwr_chg = 1'b0;
    logic vpp12 = 1'b0;
    gpeu_term_sel_t sel = '0;
    logic [4:0] ext_lvl = 5'h00;
    logic [7:0] rdata;
    logic [4:0] term_in;
    logic [4:0] term_out;
    logic [4:0] term_oe_n;
    logic evt_n;
    int miscompares = 0;
    int checked = 0;

    always #25 mclk = ~mclk;

    gpeu_top u_gpeu_top (.mclk_i(mclk), .arst_n_i(arst_n), .reg_req_i(req), .reg_rdata_o(rdata),
        .power_change_i(pwr_chg), .prog_voltage_12v_i(vpp12), .term_sel_i(sel), .term_in_i(term_in),
        .term_out_o(term_out), .term_oe_n_o(term_oe_n), .system_event_out_n_o(evt_n));
    gpeu_board u_gpeu_board (.ext_level_i(ext_lvl), .dev_out_i(term_out), .dev_oe_n_i(term_oe_n),
        .pin_level_o(term_in));

    // ------------------------------------------------------------
    // Bus helpers
    // ------------------------------------------------------------
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge mclk);
        req = '0;
    endtask : wr
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge mclk);
        req = '0;
        `CHK(rdata, exp)
    endtask : chk_rd
    task automatic pulse_power;
        @(negedge mclk);
        pwr_chg = 1'b1;
        @(negedge mclk);
        pwr_chg = 1'b0;
    endtask : pulse_power

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk_rd(GPEU_OFS_STATUS, 8'h00);
        chk_rd(GPEU_OFS_ENABLE, 8'h00);
        chk_rd(GPEU_OFS_OUTPUT, 8'h00);
        chk_rd(8'h8C, 8'h00);
        `CHK(evt_n, 1'b1)
        `CHK(term_oe_n, 5'h1F)
    endtask : t_reset
    task automatic t_regs;
        wr(GPEU_OFS_ENABLE, 8'hFF);
        chk_rd(GPEU_OFS_ENABLE, 8'hDF);
        wr(GPEU_OFS_STATUS, 8'hFF);
        chk_rd(GPEU_OFS_STATUS, 8'h00);
        `CHK(evt_n, 1'b1)
        wr(GPEU_OFS_INPUT, 8'hFF);
        chk_rd(GPEU_OFS_INPUT, 8'h00);
        wr(GPEU_OFS_OUTPUT, 8'hFF);
        chk_rd(GPEU_OFS_OUTPUT, 8'h1F);
        wr(GPEU_OFS_ENABLE, 8'h00);
    endtask : t_regs
    task automatic t_outputs;
        sel = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
        wr(GPEU_OFS_OUTPUT, 8'h15);
        idle(2);
        `CHK(term_out, 5'h15)
        `CHK(term_oe_n, 5'h00)
        sel = '0;
        idle(6);
        wr(GPEU_OFS_STATUS, 8'h1F);
        ext_lvl = 5'h0A;
        idle(5);
        chk_rd(GPEU_OFS_INPUT, 8'h0A);
        chk_rd(GPEU_OFS_STATUS, 8'h0A);
    endtask : t_outputs
    task automatic t_gpi;
        for (int i = 0; i < 5; i++) begin
            sel = gpeu_term_sel_t'(20'h5_5555 & ~(20'h0_000F << (4 * i)));
            wr(GPEU_OFS_STATUS, 8'h1F);
            ext_lvl = ~ext_lvl;
            idle(5);
            chk_rd(GPEU_OFS_STATUS, 8'(1 << i));
        end
        wr(GPEU_OFS_STATUS, 8'h1F);
        sel = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h5};
        idle(4);
        ext_lvl = ~ext_lvl;
        idle(5);
        chk_rd(GPEU_OFS_STATUS, 8'h00);
        sel = '0;
    endtask : t_gpi
    task automatic t_power;
        wr(GPEU_OFS_ENABLE, 8'h80);
        pulse_power();
        `CHK(evt_n, 1'b1)
        idle(1);
        `CHK(evt_n, 1'b0)
        chk_rd(GPEU_OFS_STATUS, 8'h80);
        wr(GPEU_OFS_STATUS, 8'h00);
        idle(1);
        `CHK(evt_n, 1'b0)
        wr(GPEU_OFS_STATUS, 8'h80);
        idle(1);
        `CHK(evt_n, 1'b1)
        wr(GPEU_OFS_ENABLE, 8'h00);
        pulse_power();
        idle(3);
        `CHK(evt_n, 1'b1)
        chk_rd(GPEU_OFS_STATUS, 8'h80);
        wr(GPEU_OFS_STATUS, 8'h80);
        @(negedge mclk);
        req = '{rd: 1'b0, wr: 1'b1, addr: GPEU_OFS_STATUS, wdata: 8'h80};
        pwr_chg = 1'b1;
        @(negedge mclk);
        req = '0;
        pwr_chg = 1'b0;
        chk_rd(GPEU_OFS_STATUS, 8'h80);
        wr(GPEU_OFS_STATUS, 8'h80);
    endtask : t_power
    task automatic t_vpp;
        wr(GPEU_OFS_ENABLE, 8'h40);
        @(negedge mclk);
        vpp12 = 1'b1;
        idle(3);
        chk_rd(GPEU_OFS_STATUS, 8'h40);
        `CHK(evt_n, 1'b0)
        wr(GPEU_OFS_STATUS, 8'h40);
        vpp12 = 1'b0;
        idle(3);
        chk_rd(GPEU_OFS_STATUS, 8'h40);
        wr(GPEU_OFS_STATUS, 8'h40);
        wr(GPEU_OFS_ENABLE, 8'h00);
    endtask : t_vpp
    task automatic t_evt_pin;
        sel = '{4'hE, 4'hE, 4'hE, 4'hE, 4'h0};
        idle(2);
        `CHK(term_oe_n, 5'h03)
        `CHK(term_out[4:2], 3'b111)
        wr(GPEU_OFS_ENABLE, 8'h80);
        pulse_power();
        idle(3);
        `CHK(term_out[4:2], 3'b000)
        wr(GPEU_OFS_STATUS, 8'h80);
        wr(GPEU_OFS_ENABLE, 8'h00);
        sel = '0;
        idle(6);
        wr(GPEU_OFS_STATUS, 8'hFF);
    endtask : t_evt_pin
    task automatic t_greset;
        wr(GPEU_OFS_OUTPUT, 8'h1F);
        wr(GPEU_OFS_ENABLE, 8'hDF);
        pulse_power();
        arst_n = 1'b0;
        idle(2);
        arst_n = 1'b1;
        `CHK(evt_n, 1'b1)
        chk_rd(GPEU_OFS_STATUS, 8'h00);
        chk_rd(GPEU_OFS_ENABLE, 8'h00);
        chk_rd(GPEU_OFS_OUTPUT, 8'h00);
        `CHK(term_out, 5'h00)
    endtask : t_greset

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic complete_run;
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    initial begin
        idle(12);
        arst_n = 1'b1;
        t_reset();
        t_regs();
        t_outputs();
        t_gpi();
        t_power();
        t_vpp();
        t_evt_pin();
        t_greset();
        complete_run();
    end

    initial begin
        repeat (4000) @(posedge mclk);
        miscompares++;
        complete_run();
    end
endmodule : tb
